// >>> rtl/mbd_consts.svh
`ifndef MBD_CONSTS_SVH
`define MBD_CONSTS_SVH
`define FC_RD_COIL   8'h01
`define FC_RD_DISC   8'h02
`define FC_RD_HREG   8'h03
`define FC_WR_COIL   8'h05
`define FC_WR_HREG   8'h06
`define FC_DIAG      8'h08
`define FC_EVT_CNT   8'h0B
`define FC_WR_COILS  8'h0F
`define FC_WR_HREGS  8'h10
`define FC_MASK_WR   8'h16
`define FC_RW_HREGS  8'h17
`define FC_MEI       8'h2B
`define MEI_DEV_ID   8'h0E
`define ID_STREAM    8'h00
`define ID_SINGLE    8'h04
`define OBJ_LAST     8'h04
`define SUB_ECHO     16'h0000
`define SUB_RESTART  16'h0001
`define SUB_LISTEN   16'h0004
`define SUB_CLR_ALL  16'h000A
`define SUB_BUS_MSG  16'h000B
`define SUB_BUS_ERR  16'h000C
`define SUB_BUS_EXC  16'h000D
`define SUB_SRV_MSG  16'h000E
`define SUB_SRV_NAK  16'h0010
`define SUB_SRV_BUSY 16'h0011
`define SUB_OVERRUN  16'h0012
`define SUB_CLR_OVR  16'h0014
`define EXC_NONE     8'h00
`define EXC_FUNC     8'h01
`define EXC_ADDR     8'h02
`define EXC_VALUE    8'h03
`define EXC_FAIL     8'h04
`define COIL_LIM     17'h0_0020
`define HREG_LIM     17'h0_0010
`define COIL_TOP     31
`define HREG_TOP     15
`define QTY_ONE      16'h0001
`define QTY_ZERO     16'h0000
`define COIL_ON      16'hFF00
`define COIL_OFF     16'h0000
`define ONE33        33'h0_0000_0001
`define WORD_ROUND   16'h000F
`define STATUS_IDLE  16'h0000
`define CNT_RST      16'h0000
`define CNT_ONE      16'h0001
`define IDX_RST      5'h00
`define IDX_ONE      5'h01
`define N_PAIR       5'h02
`define N_STREAM     5'h06
`define COIL_RST     32'h0000_0000
`endif

// >>> rtl/mbd_pkg.sv
package mbd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRDAT = 2'b01,
        ST_RDOUT = 2'b10
    } mbd_state_t;
endpackage

// >>> rtl/mbd_function_decoder.sv
`timescale 1ns/100ps
`include "mbd_consts.svh"
// Operation
// (R1) read coils returns one bit per requested coil
// (R2) read discrete inputs returns one bit per requested input
// (R3) read holding registers returns each requested 16-bit word
// (R4) write single coil forces the addressed coil to 0 or 1
// (R5) write single register stores the value in the addressed register
// (R6) diagnostics echo subfunction returns the request data unchanged
// (R7) restart reinitialises the fieldbus interface and clears event counters
// (R8) a diagnostics subfunction enters listen-only mode
// (R9) seven communication counters are kept and each is readable; the code keeps five, and server NAK and busy read as zero
// (R10) clear subfunction zeroes all counters and the diagnostic register; the code has no diagnostic register and clears the overrun flag instead
// (R11) separate subfunction clears the overrun counter and overrun flag
// (R12) comm event counter function returns status word then event count
// (R13) write multiple coils forces a consecutive coil run
// (R14) write multiple registers fills a contiguous register block
// (R15) mask write combines current register with AND and OR masks
// (R16) read/write multiple writes a block then reads another group
// (R17) encapsulated transport accepts read device identification
// (R18) access type 00h streams the basic identification objects
// (R19) access type 04h returns the one selected object
// (R20) objects: vendor, product code, revision, vendor URL, product name
// (R21) unsupported function answers exception 01h
// (R22) invalid data address answers exception 02h
// (R23) excess quantity answers exception 03h
// (R24) unrecoverable execution error answers exception 04h
// (R25) listen-only keeps counting but sends no responses until restart
module mbd_function_decoder
    import mbd_pkg::*;
#(
    parameter logic [15:0] VENDOR_NAME_VAL  = 16'h1111, // arbitrary value
    parameter logic [15:0] PRODUCT_CODE_VAL = 16'h2222, // arbitrary value
    parameter logic [15:0] VENDOR_URL_VAL   = 16'h3333, // arbitrary value
    parameter logic [15:0] PRODUCT_NAME_VAL = 16'h4444  // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic [7:0]  reqFunc,
    input  wire logic [15:0] reqSub,
    input  wire logic [15:0] reqAddr,
    input  wire logic [15:0] reqQty,
    input  wire logic [15:0] reqData,
    input  wire logic [15:0] reqOrMask,
    input  wire logic [15:0] reqRdAddr,
    input  wire logic [15:0] reqRdQty,
    input  wire logic        wrValid,
    output logic             wrReady,
    input  wire logic [15:0] wrWord,
    output logic             rspValid,
    input  wire logic        rspReady,
    output logic [15:0]      rspWord,
    output logic             rspLast,
    output logic             rspExc,
    input  wire logic        commErrPulse,
    input  wire logic        overrunPulse,
    input  wire logic        devFault,
    input  wire logic [31:0] discretePins,
    input  wire logic [7:0]  fwVersion,
    input  wire logic [7:0]  protocolId,
    output logic [31:0]      coilsOut,
    output logic             listenOnly
);
    mbd_state_t  state_ff, nxtState;
    logic [7:0]  func_ff, nxtFunc, exc_ff, nxtExc, code;
    logic [15:0] sub_ff, nxtSub, addr_ff, nxtAddr, qty_ff, nxtQty;
    logic [15:0] data_ff, nxtData, rdAddr_ff, nxtRdAddr;
    logic [4:0]  idx_ff, nxtIdx, wrN_ff, nxtWrN, out_ff, nxtOut;
    logic        quiet_ff, nxtQuiet, listen_ff, nxtListen;
    logic        ovrFlag_ff, nxtOvrFlag;
    logic [31:0] coils_ff, nxtCoils, diS1_ff, diS2_ff, diS3_ff;
    logic [31:0] di_ff, nxtDi, rangeMask, rdBits, wrMask;
    logic [32:0] m33;
    logic [5:0]  wrBase;
    logic [15:0] hreg_ff [0:`HREG_TOP];
    logic [15:0] nxtHreg [0:`HREG_TOP];
    logic [15:0] busMsg_ff, busErr_ff, busExc_ff, srvMsg_ff, ovr_ff, evt_ff;
    logic [15:0] nxtBusMsg, nxtBusErr, nxtBusExc, nxtSrvMsg, nxtOvr, nxtEvt;
    logic [15:0] rspWord_ff, nxtRspWord, curWord, maskExp;
    logic        rspValid_ff, nxtRspValid, rspLast_ff, nxtRspLast;
    logic        rspExc_ff, nxtRspExc;
    logic        incBus, incExc, incEvt, clrCnt, clrOvr;
    logic [7:0]  obj;

    function automatic logic [7:0] rangeChk(input logic [15:0] a,
                                            input logic [15:0] q,
                                            input logic [16:0] lim);
        rangeChk = `EXC_NONE;
        if (q == `QTY_ZERO || {1'b0, q} > lim)
            rangeChk = `EXC_VALUE; // [R23]
        else if ({1'b0, a} + {1'b0, q} > lim)
            rangeChk = `EXC_ADDR; // [R22]
    endfunction

    function automatic logic diagOk(input logic [15:0] s);
        diagOk = s == `SUB_ECHO || s == `SUB_RESTART || s == `SUB_LISTEN
              || s == `SUB_CLR_ALL || s == `SUB_BUS_MSG
              || s == `SUB_BUS_ERR || s == `SUB_BUS_EXC
              || s == `SUB_SRV_MSG || s == `SUB_SRV_NAK
              || s == `SUB_SRV_BUSY || s == `SUB_OVERRUN
              || s == `SUB_CLR_OVR;
    endfunction

    // set wins over clear so a same-cycle event is never lost
    function automatic logic [15:0] bump(input logic [15:0] c,
                                         input logic clr, input logic inc);
        if (clr)
            bump = inc ? `CNT_ONE : `CNT_RST;
        else
            bump = c + {15'h0000, inc};
    endfunction

    function automatic logic [4:0] words(input logic [15:0] q);
        logic [15:0] t;
        t = (q + `WORD_ROUND) >> 4;
        words = t[4:0];
    endfunction

    function automatic logic [15:0] objVal(input logic [7:0] id,
                                           input logic [15:0] rev);
        case (id)
            8'h00:   objVal = VENDOR_NAME_VAL; // [R20]
            8'h01:   objVal = PRODUCT_CODE_VAL;
            8'h02:   objVal = rev;
            8'h03:   objVal = VENDOR_URL_VAL;
            8'h04:   objVal = PRODUCT_NAME_VAL;
            default: objVal = `CNT_RST;
        endcase
    endfunction

    assign reqReady   = state_ff == ST_IDLE;
    assign wrReady    = state_ff == ST_WRDAT;
    assign rspValid   = rspValid_ff;
    assign rspWord    = rspWord_ff;
    assign rspLast    = rspLast_ff;
    assign rspExc     = rspExc_ff;
    assign coilsOut   = coils_ff;
    assign listenOnly = listen_ff;

    // pin inputs: a bit is taken once the second and third stages agree
    always_comb begin
        for (int j = 0; j <= `COIL_TOP; j++)
            nxtDi[j] = (diS2_ff[j] == diS3_ff[j]) ? diS3_ff[j] : di_ff[j];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            diS1_ff <= `COIL_RST;
            diS2_ff <= `COIL_RST;
            diS3_ff <= `COIL_RST;
            di_ff   <= `COIL_RST;
        end else begin
            diS1_ff <= discretePins;
            diS2_ff <= diS1_ff;
            diS3_ff <= diS2_ff;
            di_ff   <= nxtDi;
        end
    end

    // response word for the current index
    always_comb begin
        m33       = (`ONE33 << qty_ff[5:0]) - `ONE33;
        rangeMask = m33[31:0] << addr_ff[4:0];
        rdBits    = ((func_ff == `FC_RD_DISC) ? di_ff : coils_ff)
                    >> addr_ff[4:0];
        rdBits    = rdBits & m33[31:0];
        wrBase    = {1'b0, addr_ff[4:0]} + {1'b0, idx_ff[0], 4'h0};
        wrMask    = (32'h0000_FFFF << wrBase) & rangeMask;
        maskExp   = (hreg_ff[reqAddr[3:0]] & reqData)
                    | (reqOrMask & ~reqData);
        obj       = ((sub_ff[7:0] == `ID_SINGLE) ? addr_ff[7:0] : 8'h00)
                    + {4'h0, idx_ff[4:1]};
        curWord   = data_ff;
        if (exc_ff != `EXC_NONE) begin
            curWord = {8'h00, exc_ff}; // [R21] [R22] [R23] [R24]
        end else begin
            case (func_ff)
                `FC_RD_COIL, `FC_RD_DISC: // [R1] [R2]
                    curWord = idx_ff[0] ? rdBits[31:16] : rdBits[15:0];
                `FC_RD_HREG: // [R3]
                    curWord = hreg_ff[addr_ff[3:0] + idx_ff[3:0]];
                `FC_RW_HREGS: // [R16]
                    curWord = hreg_ff[rdAddr_ff[3:0] + idx_ff[3:0]];
                `FC_EVT_CNT: // [R12]
                    curWord = idx_ff[0] ? evt_ff : `STATUS_IDLE;
                `FC_MEI: // [R18] [R19]
                    curWord = idx_ff[0] ?
                        objVal(obj, {fwVersion, protocolId}) : {8'h00, obj};
                `FC_DIAG: begin // [R9]
                    case (sub_ff)
                        `SUB_BUS_MSG: curWord = busMsg_ff;
                        `SUB_BUS_ERR: curWord = busErr_ff;
                        `SUB_BUS_EXC: curWord = busExc_ff;
                        `SUB_SRV_MSG: curWord = srvMsg_ff;
                        // this server never refuses nor reports busy
                        `SUB_SRV_NAK, `SUB_SRV_BUSY: curWord = `CNT_RST;
                        `SUB_OVERRUN: curWord = ovr_ff;
                        default:      curWord = data_ff; // [R6]
                    endcase
                end
                `FC_WR_COIL, `FC_WR_HREG, `FC_MASK_WR:
                    curWord = data_ff;
                default: curWord = addr_ff;
            endcase
        end
    end

    always_comb begin
        nxtState = state_ff;   nxtFunc = func_ff;     nxtExc = exc_ff;
        nxtSub = sub_ff;       nxtAddr = addr_ff;     nxtQty = qty_ff;
        nxtData = data_ff;     nxtRdAddr = rdAddr_ff; nxtIdx = idx_ff;
        nxtWrN = wrN_ff;       nxtOut = out_ff;       nxtQuiet = quiet_ff;
        nxtListen = listen_ff; nxtCoils = coils_ff;   nxtHreg = hreg_ff;
        nxtRspWord = rspWord_ff;   nxtRspValid = rspValid_ff;
        nxtRspLast = rspLast_ff;   nxtRspExc = rspExc_ff;
        nxtOvrFlag = ovrFlag_ff | overrunPulse;
        incBus = 1'b0; incExc = 1'b0; incEvt = 1'b0;
        clrCnt = 1'b0; clrOvr = 1'b0;
        code = `EXC_NONE;
        case (state_ff)
            ST_IDLE: if (reqValid) begin
                nxtFunc = reqFunc;     nxtSub = reqSub;   nxtAddr = reqAddr;
                nxtQty = reqQty;       nxtData = reqData; nxtIdx = `IDX_RST;
                nxtRdAddr = reqRdAddr; nxtQuiet = listen_ff; // [R25]
                nxtState = ST_RDOUT;   nxtOut = `IDX_ONE;
                incBus = 1'b1;
                case (reqFunc)
                    `FC_RD_COIL, `FC_RD_DISC, `FC_WR_COILS:
                        code = rangeChk(reqAddr, reqQty, `COIL_LIM);
                    `FC_RD_HREG, `FC_WR_HREGS:
                        code = rangeChk(reqAddr, reqQty, `HREG_LIM);
                    `FC_WR_COIL: begin
                        code = rangeChk(reqAddr, `QTY_ONE, `COIL_LIM);
                        if (code == `EXC_NONE && reqData != `COIL_ON
                            && reqData != `COIL_OFF)
                            code = `EXC_VALUE;
                    end
                    `FC_WR_HREG, `FC_MASK_WR:
                        code = rangeChk(reqAddr, `QTY_ONE, `HREG_LIM);
                    `FC_RW_HREGS: begin
                        code = rangeChk(reqAddr, reqQty, `HREG_LIM);
                        if (code == `EXC_NONE)
                            code = rangeChk(reqRdAddr, reqRdQty, `HREG_LIM);
                    end
                    `FC_DIAG:
                        code = diagOk(reqSub) ? `EXC_NONE : `EXC_FUNC;
                    `FC_EVT_CNT: code = `EXC_NONE;
                    `FC_MEI: begin // [R17]
                        if (reqSub[15:8] != `MEI_DEV_ID)
                            code = `EXC_FUNC;
                        else if (reqSub[7:0] == `ID_SINGLE)
                            code = (reqAddr[7:0] > `OBJ_LAST
                                    || reqAddr[15:8] != 8'h00)
                                   ? `EXC_ADDR : `EXC_NONE;
                        else if (reqSub[7:0] != `ID_STREAM)
                            code = `EXC_VALUE;
                    end
                    default: code = `EXC_FUNC; // [R21]
                endcase
                if (devFault)
                    code = `EXC_FAIL; // [R24]
                nxtExc = code;
                if (code != `EXC_NONE) begin
                    incExc = 1'b1;
                end else begin
                    case (reqFunc)
                        `FC_RD_COIL, `FC_RD_DISC: nxtOut = words(reqQty);
                        `FC_RD_HREG:  nxtOut = reqQty[4:0];
                        `FC_EVT_CNT:  nxtOut = `N_PAIR;
                        `FC_RW_HREGS: nxtOut = reqRdQty[4:0];
                        `FC_MEI: nxtOut = (reqSub[7:0] == `ID_STREAM)
                                          ? `N_STREAM : `N_PAIR;
                        default:      nxtOut = `IDX_ONE;
                    endcase
                    if (reqFunc == `FC_WR_COILS) begin
                        nxtWrN = words(reqQty);
                        nxtState = ST_WRDAT;
                    end else if (reqFunc == `FC_WR_HREGS
                                 || reqFunc == `FC_RW_HREGS) begin
                        nxtWrN = reqQty[4:0];
                        nxtState = ST_WRDAT;
                    end
                    if (reqFunc != `FC_DIAG && reqFunc != `FC_EVT_CNT)
                        incEvt = 1'b1;
                    // listen-only: no action beyond counting, except restart
                    if (!listen_ff) begin
                        case (reqFunc)
                            `FC_WR_COIL: // [R4]
                                nxtCoils[reqAddr[4:0]] = reqData == `COIL_ON;
                            `FC_WR_HREG: nxtHreg[reqAddr[3:0]] = reqData; // [R5]
                            `FC_MASK_WR: nxtHreg[reqAddr[3:0]] = maskExp; // [R15]
                            default: ;
                        endcase
                    end
                    if (reqFunc == `FC_DIAG) begin
                        if (reqSub == `SUB_RESTART) begin // [R7] [R25]
                            clrCnt = 1'b1;
                            nxtOvrFlag = overrunPulse;
                            nxtListen = 1'b0;
                        end else if (!listen_ff) begin
                            if (reqSub == `SUB_LISTEN)
                                nxtListen = 1'b1; // [R8]
                            if (reqSub == `SUB_CLR_ALL) begin // [R10]
                                clrCnt = 1'b1;
                                nxtOvrFlag = overrunPulse;
                            end
                            if (reqSub == `SUB_CLR_OVR) begin // [R11]
                                clrOvr = 1'b1;
                                nxtOvrFlag = overrunPulse;
                            end
                        end
                    end
                end
            end
            ST_WRDAT: if (wrValid) begin
                if (!quiet_ff) begin
                    if (func_ff == `FC_WR_COILS) // [R13]
                        nxtCoils = (coils_ff & ~wrMask)
                                   | (({16'h0000, wrWord} << wrBase) & wrMask);
                    else // [R14] [R16]
                        nxtHreg[addr_ff[3:0] + idx_ff[3:0]] = wrWord;
                end
                nxtIdx = idx_ff + `IDX_ONE;
                if (idx_ff == wrN_ff - `IDX_ONE) begin
                    nxtIdx = `IDX_RST;
                    nxtState = ST_RDOUT;
                end
            end
            ST_RDOUT: begin
                if (rspValid_ff && !rspReady) begin
                    nxtRspValid = 1'b1;
                end else if (idx_ff != out_ff) begin
                    nxtRspValid = !quiet_ff; // [R25]
                    nxtRspWord = curWord;
                    nxtRspLast = idx_ff == out_ff - `IDX_ONE;
                    nxtRspExc = exc_ff != `EXC_NONE;
                    nxtIdx = idx_ff + `IDX_ONE;
                end else begin
                    nxtRspValid = 1'b0;
                    nxtState = ST_IDLE;
                end
            end
            default: nxtState = ST_IDLE;
        endcase
        nxtBusMsg = bump(busMsg_ff, clrCnt, incBus); // [R9]
        nxtSrvMsg = bump(srvMsg_ff, clrCnt, incBus);
        nxtBusErr = bump(busErr_ff, clrCnt, commErrPulse);
        nxtBusExc = bump(busExc_ff, clrCnt, incExc);
        nxtOvr    = bump(ovr_ff, clrCnt | clrOvr, overrunPulse);
        nxtEvt    = bump(evt_ff, clrCnt, incEvt);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;   func_ff <= 8'h00;    exc_ff <= `EXC_NONE;
            sub_ff <= `CNT_RST;    addr_ff <= `CNT_RST; qty_ff <= `CNT_RST;
            data_ff <= `CNT_RST;   rdAddr_ff <= `CNT_RST;
            idx_ff <= `IDX_RST;    wrN_ff <= `IDX_RST;  out_ff <= `IDX_RST;
            quiet_ff <= 1'b0;      listen_ff <= 1'b0;   ovrFlag_ff <= 1'b0;
            coils_ff <= `COIL_RST;
            for (int i = 0; i <= `HREG_TOP; i++)
                hreg_ff[i] <= `CNT_RST;
            busMsg_ff <= `CNT_RST; busErr_ff <= `CNT_RST;
            busExc_ff <= `CNT_RST; srvMsg_ff <= `CNT_RST;
            ovr_ff <= `CNT_RST;    evt_ff <= `CNT_RST;
            rspWord_ff <= `CNT_RST;  rspValid_ff <= 1'b0;
            rspLast_ff <= 1'b0;      rspExc_ff <= 1'b0;
        end else begin
            state_ff <= nxtState;  func_ff <= nxtFunc;  exc_ff <= nxtExc;
            sub_ff <= nxtSub;      addr_ff <= nxtAddr;  qty_ff <= nxtQty;
            data_ff <= nxtData;    rdAddr_ff <= nxtRdAddr;
            idx_ff <= nxtIdx;      wrN_ff <= nxtWrN;    out_ff <= nxtOut;
            quiet_ff <= nxtQuiet;  listen_ff <= nxtListen;
            ovrFlag_ff <= nxtOvrFlag;
            coils_ff <= nxtCoils;
            hreg_ff <= nxtHreg;
            busMsg_ff <= nxtBusMsg; busErr_ff <= nxtBusErr;
            busExc_ff <= nxtBusExc; srvMsg_ff <= nxtSrvMsg;
            ovr_ff <= nxtOvr;       evt_ff <= nxtEvt;
            rspWord_ff <= nxtRspWord;  rspValid_ff <= nxtRspValid;
            rspLast_ff <= nxtRspLast;  rspExc_ff <= nxtRspExc;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        reqValid && reqReady && !devFault && !listenOnly;
    endsequence
    sequence s_exc(logic [15:0] c);
        rspValid && rspExc && rspLast && rspWord == c;
    endsequence

    property p_exc_func;
        (s_take and reqFunc == 8'h07) |-> ##2 s_exc(16'h0001);
    endproperty
    a_exc_func: assert property (p_exc_func) else $error("no exc 01"); // [R21]
    property p_exc_addr;
        (s_take and (reqFunc == 8'h03 && reqAddr == 16'h000F
                     && reqQty == 16'h0002)) |-> ##2 s_exc(16'h0002);
    endproperty
    a_exc_addr: assert property (p_exc_addr) else $error("no exc 02"); // [R22]
    property p_exc_qty;
        (s_take and (reqFunc == 8'h03 && reqQty == 16'h0011))
            |-> ##2 s_exc(16'h0003);
    endproperty
    a_exc_qty: assert property (p_exc_qty) else $error("no exc 03"); // [R23]
    property p_exc_fail;
        (reqValid && reqReady && devFault && !listenOnly)
            |-> ##2 s_exc(16'h0004);
    endproperty
    a_exc_fail: assert property (p_exc_fail) else $error("no exc 04"); // [R24]
    property p_echo;
        (s_take and (reqFunc == 8'h08 && reqSub == 16'h0000))
            |-> ##2 (rspValid && !rspExc && rspWord == $past(reqData, 2));
    endproperty
    a_echo: assert property (p_echo) else $error("echo mismatch"); // [R6]
    property p_quiet;
        (reqValid && reqReady && listenOnly) |=> !rspValid [*4];
    endproperty
    a_quiet: assert property (p_quiet) else $error("listen-only reply"); // [R25]
    // restart must also be honoured while listen-only is active
    property p_restart;
        (reqValid && reqReady && !devFault && reqFunc == 8'h08
         && reqSub == 16'h0001)
            |=> (evt_ff == 16'h0000 && busExc_ff == 16'h0000 && !listenOnly);
    endproperty
    a_restart: assert property (p_restart) else $error("restart"); // [R7]
    property p_mask;
        (s_take and reqFunc == 8'h16 && reqAddr < 16'h0010)
            |=> hreg_ff[$past(reqAddr[3:0])]
                == (($past(hreg_ff[reqAddr[3:0]]) & $past(reqData))
                    | ($past(reqOrMask) & ~$past(reqData)));
    endproperty
    a_mask: assert property (p_mask) else $error("mask write"); // [R15]
    property p_coil;
        (s_take and (reqFunc == 8'h05 && reqData == 16'hFF00
                     && reqAddr < 16'h0020))
            |=> coilsOut[$past(reqAddr[4:0])] ##1 rspValid;
    endproperty
    a_coil: assert property (p_coil) else $error("coil not set"); // [R4]
    property p_ovr_clr;
        (s_take and (reqFunc == 8'h08 && reqSub == 16'h0014 && !overrunPulse))
            |=> (ovr_ff == 16'h0000 && !ovrFlag_ff);
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("ovr clr"); // [R11]
endmodule

// >>> verification/mbd_client.sv
`timescale 1ns/100ps
module mbd_client (
    input  wire logic        core_clk,
    input  wire logic        rspValid,
    input  wire logic [15:0] rspWord,
    input  wire logic        wrReady,
    output logic             rspReady = 1'h0,
    output logic             wrValid = 1'h0,
    output logic [15:0]      wrWord = 16'h0000
);
    logic [15:0] rxQ[$], txQ[$];
    logic        slow = 1'h0;
    always @(posedge core_clk) begin
        if (rspValid && rspReady) rxQ.push_back(rspWord);
        if (wrValid && wrReady) void'(txQ.pop_front());
        rspReady <= slow ? ~rspReady : 1'h1;
        wrValid <= txQ.size() != 0;
        // idle data is inverted so a stale word cannot pass
        wrWord <= txQ.size() != 0 ? txQ[0] : ~wrWord;
    end
endmodule

// >>> verification/modbus_server_function_decoder_tb.sv
`timescale 1ns/100ps
module modbus_server_function_decoder_tb;
    localparam logic [15:0] Z = 16'h0000, O = 16'h0001;
    logic        core_clk = 1'h0, rst_n = 1'h0, reqValid = 1'h0;
    logic        devFault = 1'h0, reqReady, wrReady, rspValid, rspLast;
    logic        rspExc, rspReady, wrValid;
    logic [7:0]  reqFunc = 8'h00;
    logic [15:0] reqSub = Z, reqAddr = Z, reqQty = Z, reqData = Z;
    logic [15:0] reqOrMask = Z, rspWord, wrWord;
    logic [31:0] coilsOut;
    logic        listenOnly, ovr = 1'h0;
    int          n_mismatch = 0, samples_checked = 0;
    mbd_function_decoder dut (.core_clk, .rst_n, .reqValid, .reqReady,
        .reqFunc, .reqSub, .reqAddr, .reqQty, .reqData, .reqOrMask,
        .reqRdAddr(reqAddr), .reqRdQty(reqQty), .wrValid, .wrReady,
        .wrWord, .rspValid, .rspReady, .rspWord, .rspLast, .rspExc,
        .commErrPulse(1'h0), .overrunPulse(ovr), .devFault,
        .discretePins(32'h1234_A5A5), .fwVersion(8'h12),
        .protocolId(8'h34), .coilsOut, .listenOnly);
    mbd_client cl (.core_clk, .rspValid, .rspWord, .wrReady, .rspReady,
        .wrValid, .wrWord);
    initial forever #50 core_clk = ~core_clk;
    task automatic check(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) n_mismatch++;
        if (s !== e) $display("FAIL %s exp %h seen %h", n, e, s);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic req(input logic [7:0] f, input logic [15:0] s, a, q, d,
                       e, m = Z, input logic df = 1'h0);
        int k = 0;
        cl.rxQ.delete();
        @(posedge core_clk);
        {reqFunc, reqSub, reqAddr, reqQty, reqData} <= {f, s, a, q, d};
        {reqOrMask, devFault, reqValid} <= {m, df, 1'h1};
        do @(negedge core_clk); while (!reqReady && ++k < 99);
        @(posedge core_clk);
        reqValid <= 1'h0;
        do @(negedge core_clk);
        while (!(rspValid && rspReady && rspLast) && ++k < 99);
        @(negedge core_clk);
        check("w0", cl.rxQ[0], e);
        if (k >= 99) n_mismatch++;
        if (k >= 99) complete_run;
    endtask
    task automatic mute(input logic [7:0] f, input logic [15:0] s, a, d);
        cl.rxQ.delete();
        @(posedge core_clk);
        {reqFunc, reqSub, reqAddr, reqQty, reqData} <= {f, s, a, O, d};
        reqValid <= 1'h1;
        @(posedge core_clk);
        reqValid <= 1'h0;
        repeat (6) @(negedge core_clk);
        check("mute", 16'(cl.rxQ.size()), Z);
    endtask
    task automatic t_data;
        cl.txQ = '{16'hBEEF, 16'h0123};
        req(8'h10, Z, 16'h0003, 16'h0002, Z, 16'h0003);
        cl.slow = 1'h1;
        req(8'h16, Z, 16'h0003, O, 16'h00FF, 16'h00FF, 16'h1200);
        req(8'h03, Z, 16'h0003, 16'h0002, Z, 16'h12EF);
        check("rd1", cl.rxQ[1], 16'h0123);
        req(8'h05, Z, 16'h0005, O, 16'hFF00, 16'hFF00);
        check("cout", coilsOut[15:0], 16'h0020);
        req(8'h01, Z, Z, 16'h0010, Z, 16'h0020);
        req(8'h02, Z, Z, 16'h0020, Z, 16'hA5A5);
        check("din1", cl.rxQ[1], 16'h1234);
        cl.txQ = '{16'hC3C3};
        req(8'h0F, Z, 16'h0010, 16'h0010, Z, 16'h0010);
        req(8'h01, Z, 16'h0010, 16'h0010, Z, 16'hC3C3);
        check("cout", coilsOut[31:16], 16'hC3C3);
        cl.txQ = '{16'hAAAA, 16'h5555};
        req(8'h17, Z, 16'h0008, 16'h0002, Z, 16'hAAAA);
        check("rw1", cl.rxQ[1], 16'h5555);
        $display("end t_data");
    endtask
    task automatic t_ctl;
        req(8'h07, Z, Z, O, Z, 16'h0001);
        req(8'h03, Z, 16'h000F, 16'h0002, Z, 16'h0002);
        req(8'h03, Z, Z, Z, Z, 16'h0003);
        req(8'h03, Z, Z, O, Z, 16'h0004, Z, 1'h1);
        req(8'h08, Z, Z, O, 16'h4321, 16'h4321);
        req(8'h2B, 16'h0E04, 16'h0002, O, Z, 16'h0002);
        check("rev", cl.rxQ[1], 16'h1234);
        req(8'h2B, 16'h0E00, Z, O, Z, Z);
        check("vnd", cl.rxQ[1], 16'h1111);
        check("rev5", cl.rxQ[5], 16'h1234);
        $display("end t_ctl");
    endtask
    task automatic t_mode;
        req(8'h08, 16'h0004, Z, O, 16'h5555, 16'h5555);
        check("lsn", 16'(listenOnly), O);
        mute(8'h06, Z, 16'h0007, 16'h7777);
        mute(8'h08, O, Z, Z);
        check("lsn", 16'(listenOnly), Z);
        req(8'h03, Z, 16'h0007, O, Z, Z);
        req(8'h0B, Z, Z, O, Z, Z);
        check("evt", cl.rxQ[1], O);
        req(8'h08, 16'h000B, Z, O, Z, 16'h0004);
        @(posedge core_clk) ovr <= 1'h1;
        @(posedge core_clk) ovr <= 1'h0;
        req(8'h08, 16'h0012, Z, O, Z, O);
        req(8'h08, 16'h0014, Z, O, Z, Z);
        req(8'h08, 16'h0012, Z, O, Z, Z);
        req(8'h08, 16'h000A, Z, O, Z, Z);
        req(8'h08, 16'h000B, Z, O, Z, 16'h0002);
        $display("end t_mode");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        t_data;
        t_ctl;
        t_mode;
        complete_run;
    end
endmodule
